// *** ascan_timing.sv ***
`timescale 1ns/1ps
// How it works
// - Low-voltage 1 clock 000: clk/32, 1-80-1
// - Low-voltage 1 clock 001: clk/16, 1-80-1
// - No-wait total: start plus 4x conv plus int
// - Normal wait 000: clk/32, 4-64-4
// - Normal wait 001: clk/16, 4-64-4
// - Wait total: stab plus 4x conv plus int
// - Sequential mode trims the wait-mode interrupt delay by three
// - Later conversions skip start and stabilization
// - Wait starts at trigger or start bit
// - Start time precedes the first conversion
module ascan_timing (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic low_power_conv_select_i,
    input wire logic conv_clock_div_bit2_i,
    input wire logic conv_clock_div_bit1_i,
    input wire logic conv_clock_div_bit0_i,
    input wire logic voltage_mode_bit1_i,
    input wire logic voltage_mode_bit0_i,
    input wire logic conversion_start_bit_i,
    input wire logic comparator_enable_bit_i,
    input wire logic wait_mode_i,
    input wire logic hw_trigger_mode_i,
    input wire logic hw_trigger_i,
    input wire logic sequential_mode_i,
    output logic conv_clock_tick_o,
    output logic busy_o,
    output logic converting_o,
    output logic [ascan_pkg::CH_W-1:0] channel_o,
    output logic conv_done_o,
    output logic scan_int_o,
    output logic setting_error_o,
    output logic [ascan_pkg::TOT_W-1:0] total_cycles_o
);
    import ascan_pkg::*;
    logic [2:0] cksel;
    logic [1:0] vmode;
    logic legal;
    logic [DIV_W-1:0] ratio;
    logic [CNT_W-1:0] pre_len, conv_len, int_len, int_base;
    logic [CNT_W-1:0] pre_len_r, conv_len_r, int_len_r, cnt_r;
    logic [CH_W-1:0] ch_r;
    logic start_d_r;
    logic tick, phase_end, sw_start, hw_start, go, run, stop;
    ascan_state_t state_r;
    assign cksel = {conv_clock_div_bit2_i, conv_clock_div_bit1_i, conv_clock_div_bit0_i};
    assign vmode = {voltage_mode_bit1_i, voltage_mode_bit0_i};

    // ----------------------------------------------------------------
    // Setting decode
    // ----------------------------------------------------------------
    // Unlisted rows are flagged and refused rather than guessed at
    always_comb
    begin
        legal = 1'b0;
        ratio = RATIO_32;
        if (!low_power_conv_select_i && cksel == CKSEL_DIV32)
        begin
            legal = 1'b1;
            ratio = RATIO_32;
        end
        else if (!low_power_conv_select_i && cksel == CKSEL_DIV16)
        begin
            legal = 1'b1;
            ratio = RATIO_16;
        end
        else if (low_power_conv_select_i && cksel == CKSEL_DIV1)
        begin
            legal = 1'b1;
            ratio = RATIO_1;
        end
        if (vmode != VMODE_NORMAL && vmode != VMODE_LOW1)
        begin
            legal = 1'b0;
        end
    end

    always_comb
    begin
        if (wait_mode_i)
        begin
            pre_len = low_power_conv_select_i ? STAB_FAST : STAB_STD;
            int_base = INT_WAIT;
        end
        else
        begin
            pre_len = START_DLY;
            int_base = INT_NOWAIT;
        end
        if (vmode == VMODE_LOW1)
        begin
            conv_len = low_power_conv_select_i ? CONV_LV_FAST : CONV_LV_STD;
        end
        else
        begin
            conv_len = low_power_conv_select_i ? CONV_NM_FAST : CONV_NM_STD;
        end
        // A one-cycle delay cannot be trimmed further, so it is left whole
        if (sequential_mode_i && int_base > SEQ_INT_TRIM)
        begin
            int_len = int_base - SEQ_INT_TRIM;
        end
        else
        begin
            int_len = int_base;
        end
    end

    assign run = comparator_enable_bit_i && legal;
    ascan_clkdiv #(
        .DIV_W(DIV_W)
    ) u_clkdiv (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .run_i(run),
        .ratio_i(ratio),
        .tick_o(tick)
    );
    // ----------------------------------------------------------------
    // Start detection
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            start_d_r <= 1'b0;
        end
        else
        begin
            start_d_r <= conversion_start_bit_i;
        end
    end

    assign sw_start = !hw_trigger_mode_i && conversion_start_bit_i && !start_d_r;
    assign hw_start = hw_trigger_mode_i && conversion_start_bit_i && hw_trigger_i;
    assign go = run && (sw_start || hw_start);
    assign stop = !conversion_start_bit_i || !run;
    assign phase_end = tick && cnt_r == CNT_ONE;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            ch_r <= '0;
        end
        else if (state_r != ST_IDLE && stop)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            ch_r <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        state_r <= ST_PRE;
                        cnt_r <= pre_len;
                        ch_r <= '0;
                    end
                end
                ST_PRE:
                begin
                    if (phase_end)
                    begin
                        state_r <= ST_CONV;
                        cnt_r <= conv_len_r;
                    end
                    else if (tick)
                    begin
                        cnt_r <= cnt_r - CNT_ONE;
                    end
                end
                ST_CONV:
                begin
                    if (phase_end && ch_r == LAST_CH)
                    begin
                        state_r <= ST_INT;
                        cnt_r <= int_len_r;
                    end
                    else if (phase_end)
                    begin
                        ch_r <= ch_r + 2'h1;
                        cnt_r <= conv_len_r;
                    end
                    else if (tick)
                    begin
                        cnt_r <= cnt_r - CNT_ONE;
                    end
                end
                ST_INT:
                begin
                    if (phase_end && sequential_mode_i)
                    begin
                        state_r <= ST_CONV;
                        cnt_r <= conv_len_r;
                        ch_r <= '0;
                    end
                    else if (phase_end)
                    begin
                        state_r <= ST_IDLE;
                        cnt_r <= '0;
                    end
                    else if (tick)
                    begin
                        cnt_r <= cnt_r - CNT_ONE;
                    end
                end
            endcase
        end
    end

    // Lengths are frozen for the scan; settings are meant to be static anyway
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            pre_len_r <= START_DLY;
            conv_len_r <= CONV_NM_STD;
            int_len_r <= INT_NOWAIT;
        end
        else if (state_r == ST_IDLE && go)
        begin
            pre_len_r <= pre_len;
            conv_len_r <= conv_len;
            int_len_r <= int_len;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            conv_done_o <= 1'b0;
            scan_int_o <= 1'b0;
            setting_error_o <= 1'b0;
            total_cycles_o <= '0;
        end
        else
        begin
            conv_done_o <= !stop && state_r == ST_CONV && phase_end;
            scan_int_o <= !stop && state_r == ST_INT && phase_end;
            setting_error_o <= comparator_enable_bit_i && !legal;
            total_cycles_o <= TOT_W'(pre_len) + TOT_W'({conv_len, 2'h0}) + TOT_W'(int_len);
        end
    end

    assign conv_clock_tick_o = tick;
    assign busy_o = state_r != ST_IDLE;
    assign converting_o = state_r == ST_CONV;
    assign channel_o = ch_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    a_div_one_tick: assert property (run && $past(run) && $past(nrst_i) && ratio == RATIO_1
        && $stable(ratio) |-> tick) else $error("Undivided clock missed a tick");
    a_div_16_gap: assert property (tick && ratio == RATIO_16 && $stable(ratio)
        |=> !tick [*8]) else $error("Divide by 16 ticked early");
    a_pre_load: assert property (state_r == ST_IDLE && go |=> state_r == ST_PRE
        && cnt_r == $past(pre_len)) else $error("Start phase length wrong");
    a_conv_load: assert property (state_r == ST_PRE && phase_end && !stop
        |=> state_r == ST_CONV && cnt_r == conv_len_r) else $error("Conversion load wrong");
    a_seq_skip: assert property (state_r == ST_INT && phase_end && !stop && sequential_mode_i
        |=> state_r == ST_CONV) else $error("Sequential repeat reentered wait");
    a_int_trim: assert property (state_r == ST_IDLE && go && sequential_mode_i && wait_mode_i
        |=> int_len_r == INT_WAIT - SEQ_INT_TRIM) else $error("Sequential trim missing");
    a_wait_stab: assert property (state_r == ST_IDLE && go && wait_mode_i
        && !low_power_conv_select_i |=> pre_len_r == STAB_STD) else $error("Wait length wrong");
    a_lv_conv: assert property (state_r == ST_IDLE && go && vmode == VMODE_LOW1
        && low_power_conv_select_i |=> conv_len_r == CONV_LV_FAST) else $error("LV conv wrong");
    a_scan_total: assert property (wait_mode_i && !low_power_conv_select_i && vmode == VMODE_NORMAL
        && !sequential_mode_i |=> total_cycles_o == TOT_W'(264)) else $error("Total wrong");
    a_irq_after_four: assert property (scan_int_o |-> $past(ch_r, 2) == LAST_CH)
        else $error("Interrupt before fourth channel");
endmodule

// *** ascan_pkg.sv ***
package ascan_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int CNT_W = 8;
    localparam int TOT_W = 10;
    localparam int DIV_W = 6;
    localparam int CH_W = 2;

    // ----------------------------------------------------------------
    // Clock select and voltage mode codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CKSEL_DIV32 = 3'h0;
    localparam logic [2:0] CKSEL_DIV16 = 3'h1;
    localparam logic [2:0] CKSEL_DIV1 = 3'h5;
    localparam logic [1:0] VMODE_NORMAL = 2'h0;
    localparam logic [1:0] VMODE_LOW1 = 2'h2;

    localparam logic [DIV_W-1:0] RATIO_32 = 6'h20;
    localparam logic [DIV_W-1:0] RATIO_16 = 6'h10;
    localparam logic [DIV_W-1:0] RATIO_1 = 6'h01;

    // ----------------------------------------------------------------
    // Phase lengths in conversion clock cycles
    // ----------------------------------------------------------------
    localparam logic [CNT_W-1:0] START_DLY = 8'h01;
    localparam logic [CNT_W-1:0] STAB_STD = 8'h04;
    localparam logic [CNT_W-1:0] STAB_FAST = 8'h06;
    localparam logic [CNT_W-1:0] CONV_LV_STD = 8'h50;
    localparam logic [CNT_W-1:0] CONV_LV_FAST = 8'h6b;
    localparam logic [CNT_W-1:0] CONV_NM_STD = 8'h40;
    localparam logic [CNT_W-1:0] CONV_NM_FAST = 8'hb5;
    localparam logic [CNT_W-1:0] INT_NOWAIT = 8'h01;
    localparam logic [CNT_W-1:0] INT_WAIT = 8'h04;
    localparam logic [CNT_W-1:0] SEQ_INT_TRIM = 8'h03;
    localparam logic [CH_W-1:0] LAST_CH = 2'h3;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PRE = 4'h2,
        ST_CONV = 4'h4,
        ST_INT = 4'h8
    } ascan_state_t;

endpackage

// *** ascan_clkdiv.sv ***
`timescale 1ns/1ps
module ascan_clkdiv #(
    parameter int DIV_W = 6
) (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic run_i,
    input wire logic [DIV_W-1:0] ratio_i,
    output logic tick_o
);
    logic [DIV_W-1:0] cnt_r;
    logic wrap;

    // Greater-or-equal so a count left above a new ratio still wraps at once
    assign wrap = (cnt_r >= ratio_i - {{(DIV_W-1){1'b0}}, 1'b1});

    // ----------------------------------------------------------------
    // Prescaler
    // ----------------------------------------------------------------
    // Restarted while stopped so the first tick lands one full period in
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || !run_i || wrap)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= run_i && wrap;
        end
    end
endmodule

// *** ascan_sw_model.sv ***
`timescale 1ns/1ps
module ascan_sw_model (
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    input wire logic [5:0] req_cfg_i,
    input wire logic req_start_i,
    input wire logic req_enable_i,
    output logic [5:0] cfg_o,
    output logic start_o,
    output logic enable_o
);
    // ----------------------------------------------------------------
    // Software side: cfg is {low power, clock select, voltage mode}
    // ----------------------------------------------------------------
    // 0.2 us at 25 ns per cycle
    localparam int QUIET_CYC = 8;
    int quiet;

    // Only listed rows are asked for, except by the refusal test
    // No sensor or internal-reference target is ever selected here
    always @(negedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            cfg_o <= 6'h02;
            start_o <= 1'b0;
            enable_o <= 1'b0;
            quiet = 0;
        end
        else if (req_cfg_i !== cfg_o)
        begin
            // Stop and disable before touching the settings
            start_o <= 1'b0;
            enable_o <= 1'b0;
            if (!start_o && !enable_o)
                quiet = quiet + 1;
            // Hold off the write until the quiet time has passed
            if (quiet >= QUIET_CYC)
                cfg_o <= req_cfg_i;
        end
        else
        begin
            quiet = 0;
            enable_o <= req_enable_i;
            start_o <= req_start_i;
        end
    end
endmodule

// *** adc_scan_timing_select_bench.sv ***
`timescale 1ns/1ps
module adc_scan_timing_select_bench;
    import ascan_pkg::*;
    // ----------------------------------------------------------------
    // Signals and row table: low-voltage no-wait, normal wait, then two extra rows
    // ----------------------------------------------------------------
    logic clk_sys_i, nrst_i, wait_mode, hw_mode, hw_trig, seq_mode;
    logic [5:0] req_cfg, cfg;
    logic req_start, req_enable, start, enable;
    logic tick, busy, conv, done, sint, serr;
    logic [CH_W-1:0] chan;
    logic [TOT_W-1:0] total;
    int bad_count, checked, cycles;
    localparam logic [5:0] ROW_CFG [8] = '{6'h02, 6'h06, 6'h36, 6'h00, 6'h04, 6'h34, 6'h34, 6'h36};
    localparam int ROW_WAIT [8] = '{0, 0, 0, 1, 1, 1, 0, 1};
    localparam int ROW_PRE [8] = '{1, 1, 1, 4, 4, 6, 1, 6};
    localparam int ROW_CONV [8] = '{80, 80, 107, 64, 64, 181, 181, 107};
    localparam int ROW_POST [8] = '{1, 1, 1, 4, 4, 4, 1, 4};
    localparam int ROW_RATIO [8] = '{32, 16, 1, 32, 16, 1, 1, 1};

    ascan_sw_model u_sw (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .req_cfg_i(req_cfg),
        .req_start_i(req_start), .req_enable_i(req_enable), .cfg_o(cfg), .start_o(start),
        .enable_o(enable));

    ascan_timing u_dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .low_power_conv_select_i(cfg[5]), .conv_clock_div_bit2_i(cfg[4]),
        .conv_clock_div_bit1_i(cfg[3]), .conv_clock_div_bit0_i(cfg[2]),
        .voltage_mode_bit1_i(cfg[1]), .voltage_mode_bit0_i(cfg[0]),
        .conversion_start_bit_i(start), .comparator_enable_bit_i(enable),
        .wait_mode_i(wait_mode), .hw_trigger_mode_i(hw_mode), .hw_trigger_i(hw_trig),
        .sequential_mode_i(seq_mode), .conv_clock_tick_o(tick), .busy_o(busy),
        .converting_o(conv), .channel_o(chan), .conv_done_o(done), .scan_int_o(sint),
        .setting_error_o(serr), .total_cycles_o(total));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %0t %s seen %0d expected %0d", $time, what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Picks a row, then measures the idle tick spacing and the reported total
    task automatic set_row(input int i);
        int t0;
        @(posedge clk_sys_i);
        req_start <= 1'b0;
        req_cfg <= ROW_CFG[i];
        req_enable <= 1'b1;
        @(negedge clk_sys_i);
        wait_mode = ROW_WAIT[i][0];
        repeat (16) @(negedge clk_sys_i);
        for (int k = 0; k < 100 && tick !== 1'b1; k++) @(negedge clk_sys_i);
        t0 = cycles;
        @(negedge clk_sys_i);
        for (int k = 0; k < 100 && tick !== 1'b1; k++) @(negedge clk_sys_i);
        check(cycles - t0, ROW_RATIO[i], "tick spacing");
        check(total, ROW_PRE[i] + 4 * ROW_CONV[i] + ROW_POST[i], "total");
        $display("test row %0d settings done", i);
    endtask

    // One whole scan, started by the start bit or by a trigger pulse
    task automatic run_scan(input int i, input bit hw);
        int n_tick, n_conv, n_done, n_busy, tot;
        n_tick = 0;
        n_conv = 0;
        n_done = 0;
        n_busy = 0;
        tot = ROW_PRE[i] + 4 * ROW_CONV[i] + ROW_POST[i];
        hw_mode = hw;
        @(posedge clk_sys_i);
        req_start <= 1'b1;
        if (hw)
        begin
            repeat (20) @(negedge clk_sys_i);
            check(busy, 1'b0, "busy before trigger");
            hw_trig = 1'b1;
        end
        for (int k = 0; k < 12000; k++)
        begin
            @(negedge clk_sys_i);
            hw_trig = 1'b0;
            n_busy += busy;
            n_tick += busy & tick;
            n_conv += conv & tick;
            n_done += done;
            if (sint === 1'b1)
                break;
        end
        check(n_tick, tot, "scan ticks");
        check(n_conv, 4 * ROW_CONV[i], "conv ticks");
        check(n_done, 4, "channel count");
        if (ROW_RATIO[i] == 1)
            check(n_busy, tot, "busy cycles");
        @(posedge clk_sys_i);
        req_start <= 1'b0;
        @(negedge clk_sys_i);
        hw_mode = 1'b0;
        $display("test scan row %0d hw %0d done", i, hw);
    endtask

    // Two back-to-back sequential scans, then an abort
    task automatic seq_scan();
        int n, ns;
        int rec [2];
        n = 0;
        ns = 0;
        seq_mode = 1'b1;
        @(posedge clk_sys_i);
        req_start <= 1'b1;
        for (int k = 0; k < 4000 && ns < 2; k++)
        begin
            @(negedge clk_sys_i);
            if (sint === 1'b1)
            begin
                rec[ns] = n;
                ns++;
                n = 0;
            end
            n += busy & tick;
        end
        check(ns, 2, "scan count");
        check(rec[0], 6 + 4 * 181 + 1, "first seq scan");
        check(rec[1], 4 * 181 + 1, "second seq scan");
        @(posedge clk_sys_i);
        req_start <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        check(busy, 1'b0, "busy after abort");
        seq_mode = 1'b0;
        $display("test sequential done");
    endtask

    // An unlisted row must neither tick nor start
    task automatic bad_row();
        int n;
        n = 0;
        @(posedge clk_sys_i);
        req_cfg <= 6'h03;
        repeat (16) @(negedge clk_sys_i);
        check(serr, 1'b1, "setting error");
        @(posedge clk_sys_i);
        req_start <= 1'b1;
        repeat (60) @(negedge clk_sys_i) n += busy | tick;
        check(n, 0, "refused start");
        @(posedge clk_sys_i);
        req_start <= 1'b0;
        $display("test bad row done");
    endtask

    // Reset in mid-scan must drop everything and show the live total at once
    task automatic reset_mid();
        @(posedge clk_sys_i);
        req_start <= 1'b1;
        repeat (50) @(negedge clk_sys_i);
        check(busy, 1'b1, "busy mid-scan");
        nrst_i = 1'b0;
        req_start <= 1'b0;
        repeat (2) @(negedge clk_sys_i);
        check(busy | sint | done | tick, 1'b0, "outputs in reset");
        nrst_i = 1'b1;
        @(negedge clk_sys_i);
        check(total, 4 + 4 * 80 + 4, "total after mid reset");
        check(busy, 1'b0, "idle after mid reset");
        $display("test mid-scan reset done");
    endtask

    // ----------------------------------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // Longest path is about 33k cycles; the ceiling leaves ample room
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            test_done();
        end
    end

    initial
    begin
        {nrst_i, wait_mode, hw_mode, hw_trig, seq_mode} = 5'h00;
        {req_start, req_enable} = 2'h0;
        req_cfg = 6'h02;
        bad_count = 0;
        checked = 0;
        cycles = 0;
        repeat (6) @(negedge clk_sys_i);
        check(busy | sint | done, 1'b0, "reset outputs");
        nrst_i = 1'b1;
        @(negedge clk_sys_i);
        check(total, 322, "total after reset");
        for (int i = 0; i < 8; i++)
        begin
            set_row(i);
            run_scan(i, 1'b0);
        end
        run_scan(7, 1'b1);
        set_row(5);
        seq_scan();
        reset_mid();
        bad_row();
        test_done();
    end
endmodule
